// File: rtl/option_byte_config_decode.sv
// configuration byte store, programming access gate and decoder

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - option bytes reachable only in programming mode
// - blank program memory reads as FFh
// - clock source decode when RC is off
// - sector 0 size from two-bit code
// - readout protect blocks memory read and write
// - option erase under readout protect wipes memory unless write protect is also set
// - write protect locks memory and its bit
// - PLL factor bit: zero x4, one x8
// - PLL disable bit bypasses the PLL
// - RC select zero turns RC on
// - LVD code 11 off, 10 high threshold
// - watchdog hardware or software mode bit
// - halt reset bit enables reset on halt
module option_byte_config_decode
  import option_byte_config_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] nvmByte0,
  input wire logic [7:0] nvmByte1,
  input wire logic progMode,
  input wire prog_cmd_t progCmd,
  input wire logic [7:0] memData,
  input wire logic memBlank,
  input wire logic memEraseDone,
  output prog_resp_t progResp,
  output store_wr_t storeWr,
  output settings_t settings
);

  typedef struct packed {
    cfg_state_t fsm;
    logic [7:0] store0;
    logic [7:0] store1;
    prog_resp_t resp;
    store_wr_t wr;
    settings_t dec;
  } state_t;

  state_t s_q;
  state_t s_d;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic settings_t decodeBytes(input logic [7:0] b0, input logic [7:0] b1);
    settings_t r;
    clk_src_t src;
    r = '0;
    src = clk_src_t'(b0[B0_CLK_SRC_HI:B0_CLK_SRC_LO]);
    r.rcOscOn = ~b1[B1_RC_OFF];
    r.clkSource = src;
    // clock field only counts with the RC oscillator off
    r.resonatorOn = b1[B1_RC_OFF] && (src == CLK_RESONATOR);
    r.externalClock = b1[B1_RC_OFF] && (src == CLK_EXT_PORT_B || src == CLK_EXT_PORT_C);
    // port C pins are free unless the resonator owns them
    r.portCEnabled = ~r.resonatorOn;
    case (b0[B0_SECTOR_HI:B0_SECTOR_LO])
      2'b00: r.sectorZeroBytes = SECTOR_HALF_K;
      2'b01: r.sectorZeroBytes = SECTOR_ONE_K;
      2'b10: r.sectorZeroBytes = SECTOR_TWO_K;
      default: r.sectorZeroBytes = SECTOR_FOUR_K;
    endcase
    r.readoutProtect = b0[B0_READOUT];
    r.writeProtect = b0[B0_WRITE_PROT];
    r.pllOn = ~b1[B1_PLL_DISABLE];
    r.pllTimesEight = b1[B1_PLL_FACTOR];
    // codes other than the two defined ones leave the detector on at low threshold
    r.lvdOn = (b1[B1_LVD_HI:B1_LVD_LO] != LVD_OFF_CODE);
    r.lvdHighThreshold = (b1[B1_LVD_HI:B1_LVD_LO] == LVD_HIGH_CODE);
    r.watchdogHardware = ~b1[B1_WDG_SW];
    r.watchdogHaltReset = b1[B1_WATCHDOG_HALT_RESET];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic anyOpt;
  logic readLock;
  logic writeLock;

  always_comb begin
    // protection follows the stored bytes so a fresh lock acts at once
    readLock = s_q.store0[B0_READOUT];
    writeLock = s_q.store0[B0_WRITE_PROT];
    anyOpt = progCmd.optWrite | progCmd.optRead | progCmd.optErase;
    s_d = s_q;
    s_d.resp.rdValid = 1'b0;
    s_d.resp.refused = 1'b0;
    s_d.resp.memWriteGrant = 1'b0;
    s_d.resp.memEraseGrant = 1'b0;
    s_d.wr.wr = 1'b0;
    case (s_q.fsm)
      ST_LOAD: begin
        // settings are taken once per reset and then never follow later writes
        s_d.store0 = nvmByte0;
        s_d.store1 = nvmByte1;
        s_d.dec = decodeBytes(nvmByte0, nvmByte1);
        s_d.fsm = ST_RUN;
      end
      ST_RUN: begin
        if (!progMode) begin
          // outside programming mode every request is refused
          s_d.resp.refused = anyOpt | progCmd.memWrite | progCmd.memErase
                             | progCmd.memRead;
        end else if (progCmd.optErase) begin
          if (writeLock) begin
            s_d.resp.refused = 1'b1;
          end else if (readLock) begin
            s_d.resp.memEraseAll = 1'b1;
            s_d.fsm = ST_WIPE;
          end else begin
            s_d.store0 = BYTE0_DEFAULT;
            s_d.store1 = BYTE1_DEFAULT;
            s_d.wr.wr = 1'b1;
            s_d.wr.sel = 1'b0;
            s_d.wr.data = BYTE0_DEFAULT;
          end
        end else if (progCmd.optWrite) begin
          s_d.wr.wr = 1'b1;
          s_d.wr.sel = progCmd.sel;
          if (progCmd.sel) begin
            s_d.store1 = progCmd.wdata;
            s_d.wr.data = progCmd.wdata;
          end else begin
            // once set, the write-protect bit sticks
            s_d.store0 = progCmd.wdata | {7'h00, writeLock};
            s_d.wr.data = progCmd.wdata | {7'h00, writeLock};
          end
        end else if (progCmd.optRead) begin
          s_d.resp.rdValid = 1'b1;
          s_d.resp.rdData = progCmd.sel ? s_q.store1 : s_q.store0;
        end else if (progCmd.memWrite || progCmd.memErase) begin
          if (readLock || writeLock) begin
            s_d.resp.refused = 1'b1;
          end else begin
            s_d.resp.memWriteGrant = progCmd.memWrite;
            s_d.resp.memEraseGrant = progCmd.memErase;
          end
        end else if (progCmd.memRead) begin
          s_d.resp.rdValid = ~readLock;
          s_d.resp.refused = readLock;
          if (readLock) begin
            s_d.resp.rdData = REFUSED_BYTE;
          end else begin
            s_d.resp.rdData = memBlank ? BLANK_BYTE : memData;
          end
        end
      end
      ST_WIPE: begin
        // requests during the wipe are refused; options clear only after memory is gone
        s_d.resp.refused = anyOpt | progCmd.memWrite | progCmd.memErase | progCmd.memRead;
        if (memEraseDone) begin
          s_d.resp.memEraseAll = 1'b0;
          s_d.store0 = BYTE0_DEFAULT;
          s_d.store1 = BYTE1_DEFAULT;
          s_d.wr.wr = 1'b1;
          s_d.wr.sel = 1'b0;
          s_d.wr.data = BYTE0_DEFAULT;
          s_d.fsm = ST_RUN;
        end
      end
      default: begin
        s_d.fsm = ST_LOAD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.fsm <= ST_LOAD;
      s_q.store0 <= BYTE0_DEFAULT;
      s_q.store1 <= BYTE1_DEFAULT;
      s_q.dec <= decodeBytes(BYTE0_DEFAULT, BYTE1_DEFAULT);
    end else begin
      s_q <= s_d;
    end
  end

  assign progResp = s_q.resp;
  assign storeWr = s_q.wr;
  assign settings = s_q.dec;

endmodule

// File: rtl/option_byte_config_pkg.sv
// shared constants and types of the configuration byte decoder
package option_byte_config_pkg;

  // byte 0 field positions
  localparam int B0_CLK_SRC_HI = 5;
  localparam int B0_CLK_SRC_LO = 4;
  localparam int B0_SECTOR_HI = 3;
  localparam int B0_SECTOR_LO = 2;
  localparam int B0_READOUT = 1;
  localparam int B0_WRITE_PROT = 0;
  // byte 1 field positions
  localparam int B1_PLL_FACTOR = 7;
  localparam int B1_PLL_DISABLE = 6;
  localparam int B1_RC_OFF = 4;
  localparam int B1_LVD_HI = 3;
  localparam int B1_LVD_LO = 2;
  localparam int B1_WDG_SW = 1;
  localparam int B1_WATCHDOG_HALT_RESET = 0;

  // factory defaults, also the value left after an option erase
  localparam logic [7:0] BYTE0_DEFAULT = 8'h74;
  localparam logic [7:0] BYTE1_DEFAULT = 8'hEF;
  // what a blank program memory byte reads as
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [7:0] REFUSED_BYTE = 8'h00;

  // sector 0 size in bytes per code
  localparam logic [12:0] SECTOR_HALF_K = 13'h0200;
  localparam logic [12:0] SECTOR_ONE_K = 13'h0400;
  localparam logic [12:0] SECTOR_TWO_K = 13'h0800;
  localparam logic [12:0] SECTOR_FOUR_K = 13'h1000;

  localparam logic [1:0] LVD_OFF_CODE = 2'b11;
  localparam logic [1:0] LVD_HIGH_CODE = 2'b10;

  typedef enum logic [1:0] {
    CLK_RESONATOR = 2'b00,
    CLK_EXT_PORT_B = 2'b01,
    CLK_RESERVED = 2'b10,
    CLK_EXT_PORT_C = 2'b11
  } clk_src_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_RUN = 3'b010,
    ST_WIPE = 3'b100
  } cfg_state_t;

  // requests from the programming tool, one-cycle pulses
  typedef struct packed {
    logic optWrite;
    logic optRead;
    logic optErase;
    logic memWrite;
    logic memErase;
    logic memRead;
    logic sel;
    logic [7:0] wdata;
  } prog_cmd_t;

  typedef struct packed {
    logic [7:0] rdData;
    logic rdValid;
    logic refused;
    logic memWriteGrant;
    logic memEraseGrant;
    logic memEraseAll;
  } prog_resp_t;

  // write-back of a changed byte to non-volatile storage
  typedef struct packed {
    logic wr;
    logic sel;
    logic [7:0] data;
  } store_wr_t;

  typedef struct packed {
    logic rcOscOn;
    logic externalClock;
    clk_src_t clkSource;
    logic resonatorOn;
    logic portCEnabled;
    logic [12:0] sectorZeroBytes;
    logic readoutProtect;
    logic writeProtect;
    logic pllOn;
    logic pllTimesEight;
    logic lvdOn;
    logic lvdHighThreshold;
    logic watchdogHardware;
    logic watchdogHaltReset;
  } settings_t;

endpackage

// File: tb/nvm_store_model.sv
// storage model: keeps the option bytes and completes the whole-memory wipe
module nvm_store_model
  import option_byte_config_pkg::*;
(
  input wire logic clk_sys,
  input wire store_wr_t storeWr,
  input wire logic eraseAll,
  output logic [7:0] nvmByte0,
  output logic [7:0] nvmByte1,
  output logic memEraseDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt = 2'h0;
  initial nvmByte0 = 8'h74;
  initial nvmByte1 = 8'hEF;
  always @(posedge clk_sys) begin
    if (storeWr.wr) begin
      if (storeWr.sel) nvmByte1 <= storeWr.data;
      else nvmByte0 <= storeWr.data;
    end
    // a real wipe takes a while, so done comes some cycles late
    cnt <= eraseAll ? cnt + 2'h1 : 2'h0;
  end
  assign memEraseDone = &cnt;
endmodule

// File: tb/option_byte_config_decode_props.sv
// assertions on the ports of the configuration byte decoder
module option_byte_config_decode_props
  import option_byte_config_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic progMode,
  input wire prog_cmd_t progCmd,
  input wire logic memEraseDone,
  input wire prog_resp_t progResp,
  input wire store_wr_t storeWr,
  input wire settings_t settings
);
  logic [1:0] upQ;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) upQ <= 2'h0;
    else if (upQ != 2'h3) upQ <= upQ + 2'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wipeEnd;
    !progResp.memEraseAll && storeWr.wr && storeWr.data == BYTE0_DEFAULT;
  endsequence
  property p_mode;
    upQ != 2'h0 && !progMode && (progCmd.optRead || progCmd.memRead) |=> progResp.refused;
  endproperty
  a_mode: assert property (p_mode) else $error("request outside mode not refused");
  property p_read;
    upQ != 2'h0 && progCmd.optRead |=> progResp.rdValid || progResp.refused;
  endproperty
  a_read: assert property (p_read) else $error("option read not answered");
  property p_wipe;
    progResp.memEraseAll && !memEraseDone |=> progResp.memEraseAll;
  endproperty
  a_wipe: assert property (p_wipe) else $error("wipe ended early");
  property p_wipeEnd;
    progResp.memEraseAll && memEraseDone |=> s_wipeEnd;
  endproperty
  a_wipeEnd: assert property (p_wipeEnd) else $error("wipe end wrong");
  property p_hold;
    upQ == 2'h3 |-> $stable(settings);
  endproperty
  a_hold: assert property (p_hold) else $error("settings moved");
  property p_rc;
    settings.rcOscOn |-> !settings.externalClock && !settings.resonatorOn;
  endproperty
  a_rc: assert property (p_rc) else $error("clock used with rc on");
  property p_res;
    !settings.rcOscOn && settings.clkSource == CLK_RESONATOR |->
      settings.resonatorOn && !settings.portCEnabled;
  endproperty
  a_res: assert property (p_res) else $error("resonator decode wrong");
  property p_lvd;
    settings.lvdHighThreshold |-> settings.lvdOn;
  endproperty
  a_lvd: assert property (p_lvd) else $error("threshold without detector");
endmodule
bind option_byte_config_decode option_byte_config_decode_props option_byte_config_decode_props_i (
  .clk_sys, .rst_n, .progMode, .progCmd, .memEraseDone, .progResp, .storeWr, .settings);

// File: tb/test_option_byte_config_decode.sv
// self-checking bench of the configuration byte decoder
module test_option_byte_config_decode
  import option_byte_config_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] OW = 6'h20, ORD = 6'h10, OE = 6'h08, MW = 6'h04, ME = 6'h02, MR = 6'h01;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic progMode = 1'b1;
  logic memBlank = 1'b0;
  logic [7:0] memData = 8'h00;
  prog_cmd_t progCmd = '0;
  logic [7:0] nvmByte0, nvmByte1, b0, b1;
  logic memEraseDone, rc, c0;
  logic [15:0] e;
  prog_resp_t progResp, rsp;
  store_wr_t storeWr;
  settings_t settings;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_49a4;
  option_byte_config_decode option_byte_config_decode_i (.clk_sys, .rst_n, .nvmByte0,
    .nvmByte1, .progMode, .progCmd, .memData, .memBlank, .memEraseDone, .progResp,
    .storeWr, .settings);
  nvm_store_model nvm_store_model_i (.clk_sys, .storeWr, .eraseAll(progResp.memEraseAll),
    .nvmByte0, .nvmByte1, .memEraseDone);
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rq(input logic [5:0] k, input logic s, input logic [7:0] d, input logic bl);
    @(posedge clk_sys);
    progCmd <= prog_cmd_t'({k, s, d});
    memBlank <= bl;
    memData <= 8'(rnd());
    @(posedge clk_sys);
    progCmd <= '0;
    @(negedge clk_sys);
    rsp = progResp;
  endtask
  task automatic rst();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst();
    // each pass stores new bytes, reloads them through reset and checks the decode
    for (int k = 0; k < 4; k++) begin
      b0 = {2'b01, k == 0 ? 2'b00 : k == 1 ? 2'b01 : 2'b11, 2'(k), 2'b00};
      b1 = 8'(rnd()) & 8'hEF | 8'h20 | (k == 3 ? 8'h00 : 8'h10);
      // a bypassed pll is only legal with the x8 code left set
      b1[7] = b1[7] | b1[6];
      rq(OW, 1'b0, b0, 1'b0);
      rq(OW, 1'b1, b1, 1'b0);
      rq(ORD, 1'b1, 8'h00, 1'b0);
      chk({rsp.rdValid, rsp.rdData}, {1'b1, b1});
      rst();
      rc = !b1[4];
      c0 = b0[5:4] == 2'b00 && !rc;
      chk(settings.sectorZeroBytes, 16'(512 << k));
      e = {b0[5:4], rc, c0, !rc && !c0, !c0};
      chk({settings.clkSource, settings.rcOscOn, settings.resonatorOn,
        settings.externalClock, settings.portCEnabled}, e);
      e = {!b1[6], b1[7], b1[3:2] != 2'b11, b1[3:2] == 2'b10, !b1[1], b1[0]};
      chk({settings.pllOn, settings.pllTimesEight, settings.lvdOn, settings.lvdHighThreshold,
        settings.watchdogHardware, settings.watchdogHaltReset}, e);
    end
    rq(MR, 1'b0, 8'h00, 1'b1);
    chk(rsp.rdData, 8'hFF);
    rq(MR, 1'b0, 8'h00, 1'b0);
    chk(rsp.rdData, memData);
    rq(MW, 1'b0, 8'h00, 1'b0);
    chk({rsp.memWriteGrant, rsp.refused}, 2'b10);
    rq(ME, 1'b0, 8'h00, 1'b0);
    chk({rsp.memEraseGrant, rsp.refused}, 2'b10);
    // an unlocked option erase goes straight back to the defaults
    rq(OE, 1'b0, 8'h00, 1'b0);
    rq(ORD, 1'b1, 8'h00, 1'b0);
    chk(rsp.rdData, 8'hEF);
    rq(OW, 1'b0, 8'h46, 1'b0);
    rq(MR, 1'b0, 8'h00, 1'b0);
    chk({rsp.refused, rsp.rdValid, rsp.rdData}, {2'b10, 8'h00});
    rq(MW, 1'b0, 8'h00, 1'b0);
    chk(rsp.refused, 1'b1);
    rq(OE, 1'b0, 8'h00, 1'b0);
    chk(rsp.memEraseAll, 1'b1);
    for (int i = 0; i < 20 && progResp.memEraseAll; i++) @(negedge clk_sys);
    chk(progResp.memEraseAll, 1'b0);
    rq(ORD, 1'b0, 8'h00, 1'b0);
    chk(rsp.rdData, 8'h74);
    chk(nvmByte0, 8'h74);
    rq(OW, 1'b0, 8'h45, 1'b0);
    rq(MW, 1'b0, 8'h00, 1'b0);
    chk(rsp.refused, 1'b1);
    rq(OE, 1'b0, 8'h00, 1'b0);
    chk(rsp.refused, 1'b1);
    rq(OW, 1'b0, 8'h44, 1'b0);
    rq(ORD, 1'b0, 8'h00, 1'b0);
    chk(rsp.rdData, 8'h45);
    @(posedge clk_sys);
    progMode <= 1'b0;
    rq(ORD, 1'b0, 8'h00, 1'b0);
    chk(rsp.refused, 1'b1);
    finish_test();
  end
endmodule
